// file: core/dpram_host_pkg.sv
// constants for the dual-port ram port controller
package dpram_host_pkg;
	localparam int ADDR_W     = 15;
	localparam int DATA_W     = 18;
	localparam int SEM_IDX_W  = 3;
	localparam int SYNC_DEPTH = 2;
	localparam int SYNC_W     = DATA_W + 2;
	localparam int CNT_W      = 4;
	localparam int CLK_NS     = 50;

	// device timing in ns
	localparam int T_WP_NS   = 12;
	localparam int T_WH_NS   = 12;
	localparam int T_AA_NS   = 15;
	localparam int T_BAA_NS  = 15;
	localparam int T_SWRD_NS = 5;

	// least times round up, never below one cycle
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// strobes stay long enough for a collision flag to be seen through the synchroniser
	localparam logic [CNT_W-1:0] ACT_CYC = CNT_W'(ceil_cyc(T_WP_NS) + SYNC_DEPTH + ceil_cyc(T_BAA_NS));
	localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(ceil_cyc(T_AA_NS) + SYNC_DEPTH + ceil_cyc(T_BAA_NS));
	localparam logic [CNT_W-1:0] WH_CYC  = CNT_W'(ceil_cyc(T_WH_NS));
	localparam logic [CNT_W-1:0] RCV_CYC = CNT_W'(ceil_cyc(T_SWRD_NS));

	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RDATA  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// command fields
	localparam int CMD_WRITE = 0;
	localparam int CMD_SEM   = 1;
	localparam int CMD_HB    = 2;
	localparam int CMD_LB    = 3;

	// status fields
	localparam int ST_BUSY     = 0;
	localparam int ST_DONE     = 1;
	localparam int ST_MAILBOX  = 2;
	localparam int ST_COLLIDED = 3;

	localparam logic [ADDR_W-1:0] MBOX_LOW  = 15'h7FFE;
	localparam logic [ADDR_W-1:0] MBOX_HIGH = 15'h7FFF;

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACTIVE, S_WHOLD, S_END, S_RECOV} state_t;
endpackage

// file: core/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					meta[i] <= 1'b0;
					q[i]    <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i]    <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// file: core/dpram_port_host.sv
// one-port controller for an asynchronous dual-port ram with token flags
// Notes on behaviour
// - memory or token select, never both
// - address moves only outside an active write
// - no write data while device drives pins
// - token cycles keep port select high
// - slave collision applied by strobe start
// - hold strobe after collision flag clears
`timescale 1ns/10ps
module dpram_port_host (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RSTN,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic      [31:0] HRDATA,
	output logic             HRESP,
	// ram port pins
	output logic      [14:0] ADDR,
	input  wire logic [17:0] DQ_IN,
	output logic      [17:0] DQ_OUT,
	output logic             DQ_OE,
	output logic             PORT_SEL_N,
	output logic             RW_N,
	output logic             READ_EN_N,
	output logic             TOKEN_FLAG_SELECT_N,
	output logic             HIGH_BYTE_SELECT_N,
	output logic             LOW_BYTE_SELECT_N,
	input  wire logic        COLLISION_N,
	input  wire logic        MAILBOX_N
);
	dpram_host_pkg::state_t state;
	dpram_host_pkg::state_t next_state;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic        stall;
	logic        next_stall;
	logic [19:0] sync_q;
	logic [17:0] dq_s;
	logic        busy_s;
	logic        mbox_s;
	logic        d_valid;
	logic        d_wr;
	logic [7:0]  d_addr;
	logic [3:0]  cmd;
	logic [14:0] addr_reg;
	logic [17:0] wdata;
	logic [17:0] rdata;
	logic        done;
	logic        collided;
	logic        start;
	logic        op_wr;
	logic        op_sem;
	logic        sel_on;
	logic        acc;
	logic [3:0]  cmd_eff;

	// local names for the sequencer states
	localparam dpram_host_pkg::state_t S_IDLE   = dpram_host_pkg::S_IDLE;
	localparam dpram_host_pkg::state_t S_SETUP  = dpram_host_pkg::S_SETUP;
	localparam dpram_host_pkg::state_t S_ACTIVE = dpram_host_pkg::S_ACTIVE;
	localparam dpram_host_pkg::state_t S_WHOLD  = dpram_host_pkg::S_WHOLD;
	localparam dpram_host_pkg::state_t S_END    = dpram_host_pkg::S_END;
	localparam dpram_host_pkg::state_t S_RECOV  = dpram_host_pkg::S_RECOV;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);

	pin_sync #(.WIDTH(dpram_host_pkg::SYNC_W)) u_sync (
		.clk  (CLOCK),
		.rstn (RSTN),
		// flags enter inverted so reset reads them idle
		.d    ({~MAILBOX_N, ~COLLISION_N, DQ_IN}),
		.q    (sync_q)
	);
	assign dq_s   = sync_q[17:0];
	assign busy_s = sync_q[18];
	assign mbox_s = sync_q[19];

	assign acc    = HSEL && HTRANS[1] && HREADY;
	assign start  = d_valid && d_wr && d_addr == dpram_host_pkg::OFS_CMD && state == S_IDLE;
	assign op_wr  = cmd[dpram_host_pkg::CMD_WRITE];
	assign op_sem = cmd[dpram_host_pkg::CMD_SEM];
	// command as it will be, valid on the starting edge too
	assign cmd_eff = start ? HWDATA[3:0] : cmd;
	assign sel_on = next_state == S_ACTIVE || next_state == S_WHOLD;

	// bus address phase capture and read answer
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			d_valid   <= 1'b0;
			d_wr      <= 1'b0;
			d_addr    <= 8'h00;
			HREADYOUT <= 1'b1;
			HRDATA    <= 32'h0000_0000;
			HRESP     <= 1'b0;
		end else begin
			d_valid <= acc;
			if (acc) begin
				d_wr   <= HWRITE;
				d_addr <= HADDR[7:0];
			end
			if (acc && !HWRITE) begin
				HREADYOUT <= 1'b0;
			end else begin
				HREADYOUT <= 1'b1;
			end
			if (d_valid && !d_wr) begin
				unique case (d_addr)
					dpram_host_pkg::OFS_CMD:    HRDATA <= {28'h0000000, cmd};
					dpram_host_pkg::OFS_ADDR:   HRDATA <= {17'h00000, addr_reg};
					dpram_host_pkg::OFS_WDATA:  HRDATA <= {14'h0000, wdata};
					dpram_host_pkg::OFS_RDATA:  HRDATA <= {14'h0000, rdata};
					dpram_host_pkg::OFS_STATUS: HRDATA <= {28'h0000000, collided, mbox_s,
						done, state != S_IDLE};
					default:                    HRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software registers; a command while busy is dropped
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			cmd      <= 4'h0;
			addr_reg <= 15'h0000;
			wdata    <= 18'h00000;
		end else if (d_valid && d_wr) begin
			if (start) begin
				cmd <= HWDATA[3:0];
			end
			if (d_addr == dpram_host_pkg::OFS_ADDR) begin
				addr_reg <= HWDATA[14:0];
			end
			if (d_addr == dpram_host_pkg::OFS_WDATA) begin
				wdata <= HWDATA[17:0];
			end
		end
	end

	// status flags; hardware set wins over software clear
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			done     <= 1'b0;
			collided <= 1'b0;
		end else begin
			if (state == S_END) begin
				done <= 1'b1;
			end else if (start) begin
				done <= 1'b0;
			end
			if (state == S_ACTIVE && busy_s) begin
				collided <= 1'b1;
			end else if (d_valid && d_wr && d_addr == dpram_host_pkg::OFS_STATUS &&
				HWDATA[dpram_host_pkg::ST_COLLIDED]) begin
				collided <= 1'b0;
			end
		end
	end

	// access sequencer
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_stall = stall;
		unique case (state)
			S_IDLE: begin
				if (start) begin
					next_state = S_SETUP;
				end
			end
			S_SETUP: begin
				next_state = S_ACTIVE;
				next_cnt   = op_wr ? dpram_host_pkg::ACT_CYC : dpram_host_pkg::RD_CYC;
			end
			S_ACTIVE: begin
				// stall while the collision flag is low
				if (busy_s) begin
					next_stall = 1'b1;
				end else if (stall) begin
					next_stall = 1'b0;
					if (op_wr) begin
						next_state = S_WHOLD;
						next_cnt   = dpram_host_pkg::WH_CYC;
					end else begin
						next_cnt = dpram_host_pkg::RD_CYC;
					end
				end else if (cnt == 4'h1) begin
					next_state = S_END;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			S_WHOLD: begin
				if (cnt == 4'h1) begin
					next_state = S_END;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			S_END: begin
				next_state = S_RECOV;
				next_cnt   = dpram_host_pkg::RCV_CYC;
			end
			S_RECOV: begin
				if (cnt == 4'h1) begin
					next_state = S_IDLE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state <= S_IDLE;
			cnt   <= 4'h0;
			stall <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			stall <= next_stall;
		end
	end

	// read capture at the end of the access window
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rdata <= 18'h00000;
		end else if (state == S_ACTIVE && next_state == S_END && !op_wr) begin
			rdata <= dq_s;
		end
	end

	// pin drive, derived from the coming state
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ADDR                <= 15'h0000;
			DQ_OUT              <= 18'h00000;
			DQ_OE               <= 1'b0;
			PORT_SEL_N          <= 1'b1;
			RW_N                <= 1'b1;
			READ_EN_N           <= 1'b1;
			TOKEN_FLAG_SELECT_N <= 1'b1;
			HIGH_BYTE_SELECT_N  <= 1'b1;
			LOW_BYTE_SELECT_N   <= 1'b1;
		end else begin
			// address set only while selects are high
			if (state == S_IDLE && next_state == S_SETUP) begin
				// token index on low address bits
				ADDR   <= HWDATA[dpram_host_pkg::CMD_SEM] ?
					{12'h000, addr_reg[2:0]} : addr_reg;
				DQ_OUT <= HWDATA[dpram_host_pkg::CMD_SEM] ? {17'h00000, wdata[0]} : wdata;
			end
			// token access keeps port select high
			PORT_SEL_N          <= !(sel_on && !op_sem);
			TOKEN_FLAG_SELECT_N <= !(sel_on && op_sem);
			// strobe goes low before the select
			// strobe overlaps the select for the whole write
			RW_N      <= !(cmd_eff[dpram_host_pkg::CMD_WRITE] &&
				(next_state == S_SETUP || sel_on));
			READ_EN_N <= !(!op_wr && sel_on);
			// drive data only with read enable off
			DQ_OE <= op_wr && (sel_on || next_state == S_END);
			HIGH_BYTE_SELECT_N <= !(cmd_eff[dpram_host_pkg::CMD_HB] && next_state != S_IDLE &&
				next_state != S_RECOV);
			LOW_BYTE_SELECT_N  <= !(cmd_eff[dpram_host_pkg::CMD_LB] && next_state != S_IDLE &&
				next_state != S_RECOV);
		end
	end

	a_select_exclusive: assert property (!(!PORT_SEL_N && !TOKEN_FLAG_SELECT_N))
		else $error("memory and token selects low together");
	a_addr_quiet_write: assert property ($changed(ADDR) |->
		RW_N || (PORT_SEL_N && TOKEN_FLAG_SELECT_N))
		else $error("address moved inside an active write");
	a_no_data_clash: assert property (DQ_OE |-> READ_EN_N && (!RW_N || !$past(RW_N)))
		else $error("write data driven while device may drive");
	a_token_no_port: assert property (!TOKEN_FLAG_SELECT_N |-> PORT_SEL_N)
		else $error("port select low during token cycle");
	a_hold_after_flag: assert property (state == S_ACTIVE && stall && !busy_s && op_wr |->
		!RW_N ##1 !RW_N && state == S_WHOLD)
		else $error("strobe released too early after collision");
	a_strobe_first: assert property ($fell(PORT_SEL_N) && !RW_N |-> !$past(RW_N))
		else $error("select fell before write strobe");
	a_stall_on_flag: assert property (state == S_ACTIVE && busy_s |=>
		state == S_ACTIVE && stall)
		else $error("access ended while collision flag low");
	a_read_wait: assert property (acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("register read answer not one wait state");
	a_write_width: assert property ($rose(DQ_OE) |-> !RW_N [*3])
		else $error("write pulse shorter than required");

	c_mem_write: cover property (state == S_END && op_wr && !op_sem);
	c_token_read: cover property (state == S_END && !op_wr && op_sem);
	c_collision: cover property (state == S_WHOLD);
	c_mailbox: cover property ($rose(mbox_s));
endmodule

// file: verification/dpram_dev_model.sv
// behavioural model of one ram port with token flags and mailbox
`timescale 1ns/10ps
module dpram_dev_model (
	// clock for the released-pin pattern
	input  wire logic        clk,
	// port pins from the controller; collision flag from the bench
	input  wire logic [14:0] addr,
	input  wire logic [17:0] dq_out,
	input  wire logic        port_sel_n,
	input  wire logic        rw_n,
	input  wire logic        read_en_n,
	input  wire logic        token_flag_select_n,
	input  wire logic        high_byte_select_n,
	input  wire logic        low_byte_select_n,
	input  wire logic        collision_n,
	// opposite port writes our mailbox
	input  wire logic        peer_write,
	// pins back to the controller
	output logic      [17:0] dq_in,
	output logic             mailbox_n
);
	logic [17:0] mem [0:32767];
	logic [7:0]  tok = 8'hFF;
	logic [17:0] last = 18'h00000;
	logic [17:0] val;
	logic [17:0] keep;
	logic        rd;
	logic        mem_we;
	logic        tok_we;
	initial mailbox_n = 1'h1;
	// memory write only while selected, strobed and not blocked; token write ignores the collision flag
	assign mem_we = !port_sel_n && !rw_n && collision_n;
	assign tok_we = !token_flag_select_n && !rw_n;
	assign rd = !read_en_n && rw_n && (!port_sel_n || !token_flag_select_n);
	assign keep = {{9{high_byte_select_n}}, {9{low_byte_select_n}}};
	assign val = !token_flag_select_n ? {18{tok[addr[2:0]]}} : mem[addr];
	// released pins show the inverse of the last value
	assign dq_in = rd ? val : ~last;
	// write ends on the first rising control
	always @(negedge mem_we) begin
		mem[addr] <= (mem[addr] & keep) | (dq_out & ~keep);
	end
	// token written through bit 0, lone requester wins
	always @(negedge tok_we) begin
		tok[addr[2:0]] <= dq_out[0];
	end
	// peer write sets, own read clears
	always @(posedge clk) begin
		if (rd)
			last <= val;
		if (peer_write)
			mailbox_n <= 1'h0;
		else if (rd && !port_sel_n && addr == dpram_host_pkg::MBOX_LOW)
			mailbox_n <= 1'h1;
	end
endmodule

// file: verification/dpram_port_host_bench.sv
// self-checking bench for the port controller
`timescale 1ns/10ps
module dpram_port_host_bench;
	typedef struct packed {
		logic [14:0] a;
		logic [17:0] d;
		logic [3:0]  cw;
		logic [3:0]  cr;
		logic [17:0] e;
	} row_t;
	logic        CLOCK = 1'h0;
	logic        RSTN = 1'h0;
	logic        HSEL = 1'h0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0]  HTRANS = 2'h0;
	logic        HWRITE = 1'h0;
	logic [2:0]  HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic        COLLISION_N = 1'h1;
	logic        peer = 1'h0;
	logic        HREADYOUT, HRESP, DQ_OE, PORT_SEL_N, RW_N, READ_EN_N, MAILBOX_N;
	logic        TOKEN_FLAG_SELECT_N, HIGH_BYTE_SELECT_N, LOW_BYTE_SELECT_N;
	logic [31:0] HRDATA;
	logic [14:0] ADDR;
	logic [17:0] DQ_IN, DQ_OUT;
	logic [31:0] rdata;
	logic [14:0] prev_addr = 15'h0;
	logic        prev_wr = 1'h0;
	int          miscompares = 0;
	int          comparisons = 0;
	row_t        rows [0:4] = '{
		'{15'h7FFD, 18'h3FFFF, 4'hD, 4'hC, 18'h3FFFF},
		'{15'h7FFD, 18'h00000, 4'h5, 4'hC, 18'h001FF},
		'{15'h0005, 18'h00000, 4'h3, 4'h2, 18'h00000},
		'{15'h0005, 18'h00001, 4'h3, 4'h2, 18'h3FFFF},
		'{15'h0123, 18'h2AAAA, 4'hD, 4'hC, 18'h2AAAA}
	};

	dpram_port_host u_dpram_port_host (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
		.ADDR(ADDR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .PORT_SEL_N(PORT_SEL_N),
		.RW_N(RW_N), .READ_EN_N(READ_EN_N), .TOKEN_FLAG_SELECT_N(TOKEN_FLAG_SELECT_N),
		.HIGH_BYTE_SELECT_N(HIGH_BYTE_SELECT_N), .LOW_BYTE_SELECT_N(LOW_BYTE_SELECT_N),
		.COLLISION_N(COLLISION_N), .MAILBOX_N(MAILBOX_N));
	dpram_dev_model u_dpram_dev_model (.clk(CLOCK), .addr(ADDR), .dq_out(DQ_OUT),
		.port_sel_n(PORT_SEL_N), .rw_n(RW_N), .read_en_n(READ_EN_N),
		.token_flag_select_n(TOKEN_FLAG_SELECT_N), .high_byte_select_n(HIGH_BYTE_SELECT_N),
		.low_byte_select_n(LOW_BYTE_SELECT_N), .collision_n(COLLISION_N),
		.peer_write(peer), .dq_in(DQ_IN), .mailbox_n(MAILBOX_N));

	initial forever #25 CLOCK = ~CLOCK;

	task automatic finish_test();
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// waits for hready sampled high at a rising edge
	task automatic hold();
		int n;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (HREADYOUT !== 1'h1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		HSEL <= 1'h1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR <= {24'h0, a};
		hold();
		HSEL <= 1'h0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		hold();
		rdata = HRDATA;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			bus(1'h0, dpram_host_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (rdata[dpram_host_pkg::ST_DONE] !== 1'h1 && n < 40);
		if (n >= 40) begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic run(input logic [3:0] cmd);
		bus(1'h1, dpram_host_pkg::OFS_CMD, {28'h0, cmd});
		wait_done();
	endtask
	task automatic setup(input logic [14:0] a, input logic [17:0] d);
		bus(1'h1, dpram_host_pkg::OFS_ADDR, {17'h0, a});
		bus(1'h1, dpram_host_pkg::OFS_WDATA, {14'h0, d});
	endtask

	// pin discipline watched every cycle
	always @(posedge CLOCK) begin
		if (RSTN) begin
			check("both_selects", {31'h0, !PORT_SEL_N && !TOKEN_FLAG_SELECT_N}, 32'h0);
			check("drive_clash", {31'h0, DQ_OE && !READ_EN_N}, 32'h0);
			check("addr_in_write", {31'h0, prev_wr && !RW_N && !PORT_SEL_N && ADDR != prev_addr}, 32'h0);
		end
		prev_wr <= !RW_N && !PORT_SEL_N;
		prev_addr <= ADDR;
	end

	initial begin
		repeat (3) @(posedge CLOCK);
		check("ready_rst", {31'h0, HREADYOUT}, 32'h1);
		check("sel_rst", {31'h0, PORT_SEL_N}, 32'h1);
		check("oe_rst", {31'h0, DQ_OE}, 32'h0);
		RSTN <= 1'h1;
		@(posedge CLOCK);
		foreach (rows[i]) begin
			setup(rows[i].a, rows[i].d);
			run(rows[i].cw);
			run(rows[i].cr);
			bus(1'h0, dpram_host_pkg::OFS_RDATA, 32'h0);
			check("row_rdata", rdata, {14'h0, rows[i].e});
		end
		bus(1'h0, 8'h40, 32'h0);
		check("unmapped", rdata, 32'h0);
		check("hresp", {31'h0, HRESP}, 32'h0);
		// write held off, only this side flagged
		COLLISION_N <= 1'h0;
		setup(15'h000A, 18'h12345);
		bus(1'h1, dpram_host_pkg::OFS_CMD, 32'hD);
		repeat (20) @(posedge CLOCK);
		bus(1'h0, dpram_host_pkg::OFS_STATUS, 32'h0);
		check("busy_held", {30'h0, rdata[1:0]}, 32'h1);
		COLLISION_N <= 1'h1;
		wait_done();
		check("collided", {31'h0, rdata[dpram_host_pkg::ST_COLLIDED]}, 32'h1);
		run(4'hC);
		bus(1'h0, dpram_host_pkg::OFS_RDATA, 32'h0);
		check("coll_data", rdata, 32'h12345);
		// mailbox set by the peer, cleared by our read
		peer <= 1'h1;
		@(posedge CLOCK);
		peer <= 1'h0;
		repeat (4) @(posedge CLOCK);
		bus(1'h0, dpram_host_pkg::OFS_STATUS, 32'h0);
		check("mbox_set", {31'h0, rdata[dpram_host_pkg::ST_MAILBOX]}, 32'h1);
		setup(dpram_host_pkg::MBOX_LOW, 18'h0);
		run(4'hC);
		bus(1'h0, dpram_host_pkg::OFS_STATUS, 32'h0);
		check("mbox_clr", {31'h0, rdata[dpram_host_pkg::ST_MAILBOX]}, 32'h0);
		finish_test();
	end
endmodule
